// ### dpc_pkg.sv
// Package for the line protection and calibration register bank.
// Assumes a byte-wide register port with one-cycle read latency.
package dpc_pkg;
   localparam logic [7:0] DPC_ADDR_PROT_CAL   = 8'h11;
   localparam logic [7:0] DPC_ADDR_LINE_MODE  = 8'h12;
   localparam logic [7:0] DPC_ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] DPC_ADDR_IRQ_ENABLE = 8'h21;
   localparam logic [7:0] DPC_ADDR_IRQ_CLEAR  = 8'h22;
   localparam logic [7:0] DPC_ADDR_STATE      = 8'h23;
   // Protection and calibration control field positions
   localparam int DPC_BIT_MANUAL_CAL   = 6;
   localparam int DPC_BIT_AUTO_CAL_DIS = 5;
   localparam int DPC_BIT_LIMIT_EN     = 4;
   localparam int DPC_BIT_OVL_EN       = 3;
   localparam int DPC_BIT_BILL_EN      = 2;
   localparam int DPC_BIT_RX_OVL       = 1;
   localparam int DPC_BIT_BILL_TONE    = 0;
   // Interrupt status bit positions
   localparam int DPC_IRQ_RX_OVL    = 0;
   localparam int DPC_IRQ_BILL_TONE = 1;
   localparam int DPC_IRQ_OVL_DET   = 2;
   localparam int DPC_IRQ_CAL_DONE  = 3;
   localparam logic [7:0] DPC_PROT_CAL_RST  = 8'h00;
   localparam logic [7:0] DPC_LINE_MODE_RST = 8'h00;
   localparam logic [3:0] DPC_IRQ_RST       = 4'h0;
   localparam logic [3:0] DPC_LEVEL_TRIP    = 4'hf;
   localparam logic [1:0] DPC_TERM_CTR21    = 2'h3;
   localparam int DPC_CLK_MHZ        = 125;
   localparam int DPC_CAL_TIME_US    = 256;
   localparam int DPC_CAL_CYCLES     = DPC_CAL_TIME_US * DPC_CLK_MHZ;
   typedef enum logic [1:0] {
      DPC_CAL_IDLE = 2'b00,
      DPC_CAL_RUN  = 2'b01,
      DPC_CAL_DONE = 2'b11
   } dpc_cal_state_t;
endpackage : dpc_pkg

// ### dpc_regs.sv
// Protection and calibration control registers of a telephone line interface.
// Assumes line-side status inputs are asynchronous; all but line_current_level are synchronised here.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module dpc_regs
   import dpc_pkg::*;
#(
   parameter int CAL_CYCLES = DPC_CAL_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       off_hook,
   input  wire logic [1:0] dc_term_select,
   input  wire logic [3:0] line_current_level,
   input  wire logic       rx_overload_in,
   input  wire logic       billing_tone_in,
   input  wire logic       rx_track_in,
   input  wire logic       auto_cal_req,
   output logic            cal_active,
   output logic            term_current_limit,
   output logic            dc_term_disable,
   output logic            hook_current_reduce,
   output logic            billing_800_ohm,
   output logic            dc_term_drive_pin,
   output logic      [7:0] line_mode_out,
   output logic            irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when stages two and three agree
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
   logic [NSYNC-1:0] s1_nxt, s2_nxt, s3_nxt;

   assign async_in = {auto_cal_req, rx_track_in, billing_tone_in, rx_overload_in, off_hook};

   always_comb begin
      s1_nxt = async_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      for (int i = 0; i < NSYNC; i++) begin
         filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         filt_r <= '0;
      end else begin
         s1_r   <= s1_nxt;
         s2_r   <= s2_nxt;
         s3_r   <= s3_nxt;
         filt_r <= filt_nxt;
      end
   end

   logic hook_s, rxovl_s, tone_s, track_s, autocal_s;
   assign hook_s    = filt_r[0];
   assign rxovl_s   = filt_r[1];
   assign tone_s    = filt_r[2];
   assign track_s   = filt_r[3];
   assign autocal_s = filt_r[4];

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   function automatic logic wr_hit(input logic [7:0] a);
      return reg_wr && (reg_addr == a);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////////
   // Protection and calibration control register
   logic [7:0] prot_r, prot_nxt;
   logic       tone_d_r, tone_d_nxt;
   logic       tone_rise, ovl_trip, rx_set, tone_set;

   assign tone_rise = tone_s && !tone_d_r;
   assign ovl_trip  = hook_s && prot_r[DPC_BIT_OVL_EN] && (line_current_level == DPC_LEVEL_TRIP);
   assign rx_set    = rxovl_s;
   assign tone_set  = tone_rise;

   logic       cal_start;
   logic       cal_finish;

   always_comb begin
      prot_nxt   = prot_r;
      tone_d_nxt = tone_s;
      if (wr_hit(DPC_ADDR_PROT_CAL)) begin
         prot_nxt[7]                   = 1'b0;
         prot_nxt[DPC_BIT_MANUAL_CAL]  = reg_wdata[DPC_BIT_MANUAL_CAL];
         prot_nxt[DPC_BIT_AUTO_CAL_DIS] = reg_wdata[DPC_BIT_AUTO_CAL_DIS];
         prot_nxt[DPC_BIT_LIMIT_EN]    = reg_wdata[DPC_BIT_LIMIT_EN];
         prot_nxt[DPC_BIT_OVL_EN]      = reg_wdata[DPC_BIT_OVL_EN];
         prot_nxt[DPC_BIT_BILL_EN]     = reg_wdata[DPC_BIT_BILL_EN];
         // Only a written zero clears the sticky flags
         if (!reg_wdata[DPC_BIT_RX_OVL]) prot_nxt[DPC_BIT_RX_OVL] = 1'b0;
         if (!reg_wdata[DPC_BIT_BILL_TONE]) prot_nxt[DPC_BIT_BILL_TONE] = 1'b0;
      end
      if (cal_finish) prot_nxt[DPC_BIT_MANUAL_CAL] = 1'b0;
      // Hardware sets win over a same-cycle clear
      if (rx_set) prot_nxt[DPC_BIT_RX_OVL] = 1'b1;
      if (tone_set) prot_nxt[DPC_BIT_BILL_TONE] = 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prot_r   <= DPC_PROT_CAL_RST;
         tone_d_r <= 1'b0;
      end else begin
         prot_r   <= prot_nxt;
         tone_d_r <= tone_d_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protection trips: released by clearing the enable or by going on-hook
   logic       ovl_det_r, ovl_det_nxt;
   logic       bill_trip_r, bill_trip_nxt;

   always_comb begin
      ovl_det_nxt   = ovl_det_r;
      bill_trip_nxt = bill_trip_r;
      if (wr_hit(DPC_ADDR_PROT_CAL)) begin
         // Writing the enable to zero releases a tripped protection
         if (!reg_wdata[DPC_BIT_OVL_EN]) ovl_det_nxt = 1'b0;
         if (!reg_wdata[DPC_BIT_BILL_EN]) bill_trip_nxt = 1'b0;
      end
      // A trip in the same cycle as a release wins
      if (ovl_trip) ovl_det_nxt = 1'b1;
      if (hook_s && prot_r[DPC_BIT_BILL_EN] && tone_rise) begin
         bill_trip_nxt = 1'b1;
      end
      // Going on-hook drops both trips so the next call starts clean
      if (!hook_s) begin
         ovl_det_nxt   = 1'b0;
         bill_trip_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovl_det_r   <= 1'b0;
         bill_trip_r <= 1'b0;
      end else begin
         ovl_det_r   <= ovl_det_nxt;
         bill_trip_r <= bill_trip_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line mode control register
   logic [7:0] mode_r, mode_nxt;

   always_comb begin
      mode_nxt = mode_r;
      if (wr_hit(DPC_ADDR_LINE_MODE)) mode_nxt = reg_wdata;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_r <= DPC_LINE_MODE_RST;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration sequencer
   dpc_cal_state_t cal_r, cal_nxt;
   logic [31:0]    cnt_r, cnt_nxt;

   // A manual start stays set until the run completes, so one write is enough
   assign cal_start  = prot_r[DPC_BIT_MANUAL_CAL] ||
                       (autocal_s && !prot_r[DPC_BIT_AUTO_CAL_DIS]);
   assign cal_finish = (cal_r == DPC_CAL_DONE);

   always_comb begin
      cal_nxt = cal_r;
      cnt_nxt = cnt_r;
      case (cal_r)
         DPC_CAL_IDLE: begin
            if (cal_start) begin
               cal_nxt = DPC_CAL_RUN;
               cnt_nxt = 32'(CAL_CYCLES - 1);
            end
         end
         DPC_CAL_RUN: begin
            if (cnt_r == '0) cal_nxt = DPC_CAL_DONE;
            else cnt_nxt = cnt_r - 32'h1;
         end
         DPC_CAL_DONE: cal_nxt = DPC_CAL_IDLE;
         default: cal_nxt = DPC_CAL_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cal_r <= DPC_CAL_IDLE;
         cnt_r <= 32'h0;
      end else begin
         cal_r <= cal_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and clear
   logic [3:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt, irq_ev;

   // Each event is raised once, on the cycle its cause first appears
   always_comb begin
      irq_ev                    = 4'h0;
      irq_ev[DPC_IRQ_CAL_DONE]  = cal_finish;
      irq_ev[DPC_IRQ_OVL_DET]   = ovl_trip && !ovl_det_r;
      irq_ev[DPC_IRQ_BILL_TONE] = tone_set;
      irq_ev[DPC_IRQ_RX_OVL]    = rx_set && !prot_r[DPC_BIT_RX_OVL];
   end

   always_comb begin
      irq_stat_nxt = irq_stat_r;
      irq_en_nxt   = irq_en_r;
      if (wr_hit(DPC_ADDR_IRQ_CLEAR)) irq_stat_nxt = irq_stat_r & ~reg_wdata[3:0];
      irq_stat_nxt = irq_stat_nxt | irq_ev;
      if (wr_hit(DPC_ADDR_IRQ_ENABLE)) irq_en_nxt = reg_wdata[3:0];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= DPC_IRQ_RST;
         irq_en_r   <= DPC_IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_en_r   <= irq_en_nxt;
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   ////////////////////////////////////////////////////////////////////////////
   // Read port and line-side outputs
   logic [7:0] rdata_r, rdata_nxt;
   logic       drive_r, drive_nxt;
   logic       lim_r, lim_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            DPC_ADDR_PROT_CAL:   rdata_nxt = prot_r;
            DPC_ADDR_LINE_MODE:  rdata_nxt = mode_r;
            DPC_ADDR_IRQ_STATUS: rdata_nxt = {4'h0, irq_stat_r};
            DPC_ADDR_IRQ_ENABLE: rdata_nxt = {4'h0, irq_en_r};
            DPC_ADDR_STATE:      rdata_nxt = {4'h0, cal_r != DPC_CAL_IDLE, bill_trip_r, ovl_det_r, hook_s};
            default:             rdata_nxt = 8'h00;
         endcase
      end
      // Holding the pin keeps the last tracked level while the line supply collapses
      drive_nxt = bill_trip_r ? drive_r : track_s;
      lim_nxt   = prot_r[DPC_BIT_LIMIT_EN] && (dc_term_select == DPC_TERM_CTR21);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
         drive_r <= 1'b0;
         lim_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         drive_r <= drive_nxt;
         lim_r   <= lim_nxt;
      end
   end

   assign reg_rdata           = rdata_r;
   assign dc_term_drive_pin   = drive_r;
   assign term_current_limit  = lim_r;
   assign dc_term_disable     = ovl_det_r || bill_trip_r;
   assign hook_current_reduce = ovl_det_r;
   assign billing_800_ohm     = bill_trip_r;
   assign cal_active          = (cal_r != DPC_CAL_IDLE);
   assign line_mode_out       = mode_r;

endmodule : dpc_regs

// ### dpc_regs_assertions.sv
// Concurrent checks on the ports of the protection and calibration bank.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module dpc_regs_assertions
   import dpc_pkg::*;
#(
   parameter int CAL_CYCLES = DPC_CAL_CYCLES
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       off_hook,
   input wire logic [1:0] dc_term_select,
   input wire logic [3:0] line_current_level,
   input wire logic       cal_active,
   input wire logic       term_current_limit,
   input wire logic       dc_term_disable,
   input wire logic       hook_current_reduce,
   input wire logic       billing_800_ohm,
   input wire logic       dc_term_drive_pin
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Counts the sampled cycles of one calibration run
   logic [31:0] cal_len_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) cal_len_r <= 32'h0;
      else if (cal_active) cal_len_r <= cal_len_r + 32'h1;
      else cal_len_r <= 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_CAL_START: assert property (reg_wr && reg_addr == DPC_ADDR_PROT_CAL && reg_wdata[DPC_BIT_MANUAL_CAL] &&
      !cal_active |-> ##[1:3] cal_active) else $error("manual calibration did not start");
   AST_CAL_LEN: assert property ($fell(cal_active) |-> cal_len_r == 32'(CAL_CYCLES + 1))
      else $error("calibration length wrong");
   AST_LIMIT_MODE: assert property (dc_term_select != DPC_TERM_CTR21 |=> !term_current_limit)
      else $error("current limit outside its mode");
   AST_OVL_TERM: assert property (hook_current_reduce |-> dc_term_disable)
      else $error("overload trip left termination on");
   AST_OVL_CAUSE: assert property ($rose(hook_current_reduce) |-> $past(line_current_level) == DPC_LEVEL_TRIP ||
      $past(line_current_level, 2) == DPC_LEVEL_TRIP) else $error("overload trip without full level");
   AST_ON_HOOK: assert property (!off_hook [*8] |-> !hook_current_reduce && !billing_800_ohm)
      else $error("protection tripped while on hook");
   AST_BILL_TERM: assert property (billing_800_ohm |-> dc_term_disable)
      else $error("billing trip left termination on");
   AST_DRIVE_HOLD: assert property (billing_800_ohm && $past(billing_800_ohm) |-> $stable(dc_term_drive_pin))
      else $error("drive pin moved during billing trip");
endmodule : dpc_regs_assertions
bind dpc_regs dpc_regs_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .off_hook(off_hook), .dc_term_select(dc_term_select), .line_current_level(line_current_level),
   .cal_active(cal_active), .term_current_limit(term_current_limit), .dc_term_disable(dc_term_disable),
   .hook_current_reduce(hook_current_reduce), .billing_800_ohm(billing_800_ohm),
   .dc_term_drive_pin(dc_term_drive_pin));

// ### dpc_regs_tb_top.sv
// Self-checking bench for the protection and calibration bank.
// Assumes the checker file is compiled beside it.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dpc_regs_tb_top import dpc_pkg::*; ;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dpc_row_t;
   logic       core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, off_hook = 1'h0;
   logic       rx_overload_in = 1'h0, billing_tone_in = 1'h0, rx_track_in = 1'h0, auto_cal_req = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, q, reg_rdata, line_mode_out;
   logic [1:0] dc_term_select = 2'h0;
   logic [3:0] line_current_level = 4'h0;
   logic       cal_active, term_current_limit, dc_term_disable, hook_current_reduce;
   logic       billing_800_ohm, dc_term_drive_pin, irq;
   int         num_errors = 0, tests_run = 0;
   dpc_row_t   rows [6] = '{'{8'h12, 8'ha5, 8'ha5}, '{8'h12, 8'h5a, 8'h5a}, '{8'h11, 8'hbc, 8'h3c},
                            '{8'h21, 8'h0f, 8'h0f}, '{8'h22, 8'h0f, 8'h00}, '{8'h30, 8'hff, 8'h00}};
   always #4 core_clk = ~core_clk;
   dpc_regs #(.CAL_CYCLES(8)) u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .off_hook(off_hook), .dc_term_select(dc_term_select),
      .line_current_level(line_current_level), .rx_overload_in(rx_overload_in), .billing_tone_in(billing_tone_in),
      .rx_track_in(rx_track_in), .auto_cal_req(auto_cal_req), .cal_active(cal_active),
      .term_current_limit(term_current_limit), .dc_term_disable(dc_term_disable),
      .hook_current_reduce(hook_current_reduce), .billing_800_ohm(billing_800_ohm),
      .dc_term_drive_pin(dc_term_drive_pin), .line_mode_out(line_mode_out), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("mismatches %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 q = reg_rdata;
   endtask : rd
   task automatic pin(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : pin
   task automatic wait_cal(input logic want);
      int i;
      for (i = 0; i < 100 && cal_active !== want; i++) @(posedge core_clk);
      if (cal_active !== want) begin
         num_errors++;
         tally_and_finish;
      end
   endtask : wait_cal
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'h0;
      rd(DPC_ADDR_LINE_MODE);
      `CHK(q, DPC_LINE_MODE_RST)
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a);
         `CHK(q, rows[k].e)
      end
      `CHK(line_mode_out, 8'h5a)
      // Manual calibration self-clears and raises the enabled interrupt
      wr(DPC_ADDR_PROT_CAL, 8'h40);
      wait_cal(1'h1);
      wait_cal(1'h0);
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, 8'h00)
      rd(DPC_ADDR_IRQ_STATUS);
      `CHK(q, 8'h08)
      `CHK(irq, 1'h1)
      wr(DPC_ADDR_IRQ_CLEAR, 8'h0f);
      pin(1);
      `CHK(irq, 1'h0)
      // Automatic calibration held off, then allowed with its interrupt masked
      wr(DPC_ADDR_IRQ_ENABLE, 8'h00);
      wr(DPC_ADDR_PROT_CAL, 8'h20);
      auto_cal_req <= 1'h1;
      pin(30);
      `CHK(cal_active, 1'h0)
      wr(DPC_ADDR_PROT_CAL, 8'h00);
      wait_cal(1'h1);
      `CHK(cal_active, 1'h1)
      auto_cal_req <= 1'h0;
      wait_cal(1'h0);
      `CHK(irq, 1'h0)
      wr(DPC_ADDR_IRQ_CLEAR, 8'h0f);
      wr(DPC_ADDR_PROT_CAL, 8'h10);
      dc_term_select <= 2'h2;
      pin(3);
      `CHK(term_current_limit, 1'h0)
      dc_term_select <= DPC_TERM_CTR21;
      pin(3);
      `CHK(term_current_limit, 1'h1)
      rx_overload_in <= 1'h1;
      pin(8);
      rx_overload_in <= 1'h0;
      wr(DPC_ADDR_PROT_CAL, 8'h02);
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, 8'h02)
      wr(DPC_ADDR_PROT_CAL, 8'h00);
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, 8'h00)
      off_hook <= 1'h1;
      rx_track_in <= 1'h1;
      wr(DPC_ADDR_PROT_CAL, 8'h04);
      pin(8);
      `CHK(dc_term_drive_pin, 1'h1)
      billing_tone_in <= 1'h1;
      pin(8);
      `CHK(billing_800_ohm, 1'h1)
      `CHK(dc_term_disable, 1'h1)
      rx_track_in <= 1'h0;
      pin(8);
      `CHK(dc_term_drive_pin, 1'h1)
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, 8'h05)
      billing_tone_in <= 1'h0;
      wr(DPC_ADDR_PROT_CAL, 8'h00);
      pin(8);
      `CHK(dc_term_drive_pin, 1'h0)
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, 8'h00)
      wr(DPC_ADDR_PROT_CAL, 8'h08);
      line_current_level <= DPC_LEVEL_TRIP;
      pin(4);
      line_current_level <= 4'h0;
      pin(4);
      `CHK(hook_current_reduce, 1'h1)
      wr(DPC_ADDR_PROT_CAL, 8'h00);
      pin(2);
      `CHK(hook_current_reduce, 1'h0)
      // Reset in mid-run returns both control registers to their reset values
      wr(DPC_ADDR_PROT_CAL, 8'h1c);
      rst <= 1'h1;
      pin(2);
      rst <= 1'h0;
      rd(DPC_ADDR_PROT_CAL);
      `CHK(q, DPC_PROT_CAL_RST)
      rd(DPC_ADDR_LINE_MODE);
      `CHK(q, DPC_LINE_MODE_RST)
      `CHK(line_mode_out, DPC_LINE_MODE_RST)
      tally_and_finish;
   end
endmodule : dpc_regs_tb_top
